// [rtl/hxi_top.v]
// host exchange and interrupt port of the serial coprocessor unit
`timescale 1ns/1ps
`default_nettype none
`include "hxi_consts.vh"
module hxi_top (
	input  wire        clk_sys_in,        // 100 MHz system clock
	input  wire        nrst_in,           // async reset, active low
	input  wire        ce_in,             // clock enable, freezes state
	input  wire        wb_cyc_in,         // wishbone cycle
	input  wire        wb_stb_in,         // wishbone strobe
	input  wire        wb_we_in,          // wishbone write
	input  wire [7:0]  wb_adr_in,         // wishbone byte address
	input  wire [3:0]  wb_sel_in,         // wishbone byte lanes
	input  wire [31:0] wb_dat_in,         // wishbone write data
	output reg  [31:0] wb_dat_out,        // wishbone read data
	output reg         wb_ack_out,        // wishbone acknowledge
	output wire        irq_out,           // interrupt to unit cpu
	input  wire        host_refresh_in,   // high during i/o refresh
	input  wire [15:0] host_word0_in,     // allocated word n
	input  wire [15:0] host_word1_in,     // allocated word n+1
	input  wire [15:0] host_word2_in,     // allocated word n+2
	input  wire        host_sp_wr_in,     // special_unit_write strobe
	input  wire        host_sp_rd_in,     // special_unit_read strobe
	input  wire [15:0] host_sp_code_in,   // special access control code
	input  wire [15:0] host_sp_data_in,   // special write data
	output reg  [15:0] host_sp_rdata_out, // special read data
	input  wire [15:0] host_mem_rdata_in, // host memory read data
	output reg         host_mem_req_out,  // host memory access active
	output reg         host_mem_we_out,   // access writes host memory
	output reg  [7:0]  host_mem_idx_out,  // word offset in transfer
	output reg  [15:0] host_mem_wdata_out,// host memory write data
	output reg  [15:0] host_status_out,   // allocated word n+5
	output reg  [15:0] host_put_word_out, // allocated word n+6
	output reg         host_busy_out      // unit busy flag
);
	localparam ST_IDLE = 3'd0;
	localparam ST_ARM  = 3'd1;
	localparam ST_MOVE = 3'd2;
	localparam ST_REQ  = 3'd3;
	localparam ST_DONE = 3'd4;

	// every host pin passes the synchroniser before use
	wire [98:0] s_bus;
	wire        s_ref;
	wire [15:0] s_w0;
	wire [15:0] s_w1;
	wire [15:0] s_w2;
	wire        s_spwr;
	wire        s_sprd;
	wire [15:0] s_code;
	wire [15:0] s_data;
	wire [15:0] s_mrd;

	hxi_sync #(.W(99)) u_sync (
		.clk_sys_in (clk_sys_in),
		.nrst_in    (nrst_in),
		.ce_in      (ce_in),
		.d_in       ({host_refresh_in, host_word0_in, host_word1_in,
		              host_word2_in, host_sp_wr_in, host_sp_rd_in,
		              host_sp_code_in, host_sp_data_in,
		              host_mem_rdata_in}),
		.q_out      (s_bus)
	);
	assign {s_ref, s_w0, s_w1, s_w2, s_spwr, s_sprd, s_code, s_data,
		s_mrd} = s_bus;

	reg                 ref_d;
	reg                 spwr_d;
	reg                 sprd_d;
	reg                 irqbit_prev;
	reg [`HXI_NEV-1:0]  status;
	reg [`HXI_NEV-1:0]  mask;
	reg                 irq_en;
	reg [15:0]          get0;
	reg [15:0]          get1;
	reg [15:0]          put_stage;
	reg [7:0]           shm_addr;
	reg                 cc_pend;
	reg [7:0]           cc_num;
	reg                 run;
	reg [7:0]           num;
	reg                 pv;
	reg [7:0]           pn;
	reg [2:0]           state;
	reg [7:0]           xf_cnt;
	reg [7:0]           xf_idx;
	reg [7:0]           xf_base;
	reg                 xf_dir;
	reg                 xf_req;
	reg [2:0]           xf_phase;
	reg                 wr_req;
	reg                 rd_req;
	reg                 hw_pend;
	reg [7:0]           hw_idx;
	reg [15:0]          hw_data;

	wire ref_rise  = s_ref & ~ref_d;
	wire spwr_rise = s_spwr & ~spwr_d;
	wire sprd_rise = s_sprd & ~sprd_d;
	wire wb_req    = wb_cyc_in & wb_stb_in;
	wire wr_go     = wb_req & wb_we_in & wb_ack_out;
	wire is_shm    = (s_code[15:8] == `HXI_CODE_SHM);
	wire is_reqcd  = (s_code == `HXI_CODE_REQ);
	wire req_wr    = spwr_rise & is_reqcd & (state == ST_REQ) & ~xf_dir;
	wire req_rd    = sprd_rise & is_reqcd & (state == ST_REQ) & xf_dir;
	wire [7:0] xf_at = xf_base + xf_idx;

	// memory write port: bus write at its ack edge, then host, then transfer
	wire wb_shm_we  = wr_go & (wb_adr_in == `HXI_OFF_SHMDATA);
	wire host_we    = hw_pend & ~wb_shm_we;
	wire xf_capture = (state == ST_MOVE) & s_ref &
		(xf_phase == `HXI_XFER_GAP);
	wire xf_we      = xf_capture & ~xf_dir & ~wb_shm_we & ~hw_pend;
	wire xf_step    = xf_capture & (xf_dir | xf_we);
	wire        m_we    = wb_shm_we | host_we | xf_we;
	wire [7:0]  m_widx  = wb_shm_we ? shm_addr : (host_we ? hw_idx : xf_at);
	wire [15:0] m_wdata = wb_shm_we ? wb_dat_in[15:0] :
		(host_we ? hw_data : s_mrd);
	wire [15:0] m_ra;
	wire [15:0] m_rb;
	wire [15:0] m_rc;

	hxi_shmem u_mem (
		.clk_sys_in (clk_sys_in),
		.ce_in      (ce_in),
		.we_in      (m_we),
		.widx_in    (m_widx),
		.wdata_in   (m_wdata),
		.ra_idx_in  (shm_addr),
		.rb_idx_in  (is_reqcd ? xf_at : s_code[7:0]),
		.rc_idx_in  (xf_at),
		.ra_out     (m_ra),
		.rb_out     (m_rb),
		.rc_out     (m_rc)
	);

	// interrupt dispatch with a single pending slot
	reg                next_run;
	reg [7:0]          next_num;
	reg                next_pv;
	reg [7:0]          next_pn;
	reg                ev_disp;
	reg                ev_drop;
	wire               done_wr = wr_go & (wb_adr_in == `HXI_OFF_DISPATCH) &
		wb_sel_in[0] & wb_dat_in[`HXI_DONE_BIT];
	wire               ev_word = ref_rise & s_w0[`HXI_IRQ_BIT] &
		~irqbit_prev;
	wire               ev_cc   = ref_rise & cc_pend;

	always @* begin
		next_run = run;
		next_num = num;
		next_pv  = pv;
		next_pn  = pn;
		ev_disp  = 1'b0;
		ev_drop  = 1'b0;
		if (done_wr && run) begin
			if (pv && irq_en) begin
				next_num = pn;
				next_pv  = 1'b0;
				ev_disp  = 1'b1;
			end else begin
				next_run = 1'b0;
			end
		end
		if (ev_word) begin
			if (host_busy_out) begin
				ev_drop = 1'b1;
			end else if (!next_run && irq_en) begin
				next_run = 1'b1;
				next_num = s_w2[7:0];
				ev_disp  = 1'b1;
			end else if (!next_pv) begin
				next_pv = 1'b1;
				next_pn = s_w2[7:0];
			end else begin
				ev_drop = 1'b1;
			end
		end
		if (ev_cc) begin
			if (host_busy_out) begin
				ev_drop = 1'b1;
			end else if (!next_run && irq_en) begin
				next_run = 1'b1;
				next_num = cc_num;
				ev_disp  = 1'b1;
			end else if (!next_pv) begin
				next_pv = 1'b1;
				next_pn = cc_num;
			end else begin
				ev_drop = 1'b1;
			end
		end
		if (!next_run && next_pv && irq_en) begin
			next_run = 1'b1;
			next_num = next_pn;
			next_pv  = 1'b0;
			ev_disp  = 1'b1;
		end
	end

	wire [`HXI_NEV-1:0] ev;
	assign ev[`HXI_EV_DISPATCH]  = ev_disp;
	assign ev[`HXI_EV_XFER_DONE] = (state == ST_DONE) & wb_ack_out;
	assign ev[`HXI_EV_SHM_WRITE] = spwr_rise & is_shm;
	assign ev[`HXI_EV_DROPPED]   = ev_drop;
	// only toward the unit cpu; nothing signals the host
	assign irq_out = |(status & mask);

	wire [`HXI_NEV-1:0] w1c = (wr_go && wb_sel_in[0] &&
		wb_adr_in == `HXI_OFF_STATUS) ? wb_dat_in[`HXI_NEV-1:0] :
		{`HXI_NEV{1'b0}};

	always @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ref_d       <= 1'b0;
			spwr_d      <= 1'b0;
			sprd_d      <= 1'b0;
			irqbit_prev <= 1'b0;
			status      <= {`HXI_NEV{1'b0}};
			mask        <= `HXI_MASK_RST;
			irq_en      <= `HXI_CTRL_EN_RST;
			get0        <= 16'h0000;
			get1        <= 16'h0000;
			shm_addr    <= 8'h00;
			cc_pend     <= 1'b0;
			cc_num      <= 8'h00;
			run         <= 1'b0;
			num         <= 8'h00;
			pv          <= 1'b0;
			pn          <= 8'h00;
			hw_pend     <= 1'b0;
			hw_idx      <= 8'h00;
			hw_data     <= 16'h0000;
			host_sp_rdata_out <= 16'h0000;
			host_put_word_out <= `HXI_PUT_RST;
			put_stage   <= `HXI_PUT_RST;
		end else if (ce_in) begin
			ref_d  <= s_ref;
			spwr_d <= s_spwr;
			sprd_d <= s_sprd;
			run    <= next_run;
			num    <= next_num;
			pv     <= next_pv;
			pn     <= next_pn;
			// set wins over a same-cycle clear
			status <= (status & ~w1c) | ev;
			if (ref_rise) begin
				irqbit_prev <= s_w0[`HXI_IRQ_BIT];
				get0 <= s_w0;
				get1 <= s_w1;
				host_put_word_out <= put_stage;
			end
			// a new cc00 arriving at refresh stays for the next one
			if (spwr_rise && s_code == `HXI_CODE_IRQ) begin
				cc_pend <= 1'b1;
				cc_num  <= s_data[7:0];
			end else if (ref_rise) begin
				cc_pend <= 1'b0;
			end
			if ((spwr_rise && is_shm) || req_wr) begin
				hw_pend <= 1'b1;
				hw_idx  <= is_shm ? s_code[7:0] : xf_at;
				hw_data <= s_data;
			end else if (host_we) begin
				hw_pend <= 1'b0;
			end
			if (sprd_rise) begin
				host_sp_rdata_out <= m_rb;
			end
			if (wr_go) begin
				case (wb_adr_in)
				`HXI_OFF_MASK: begin
					if (wb_sel_in[0]) mask <= wb_dat_in[`HXI_NEV-1:0];
				end
				`HXI_OFF_CTRL: begin
					if (wb_sel_in[0]) irq_en <= wb_dat_in[`HXI_CTRL_EN];
				end
				`HXI_OFF_PUT: begin
					// staged here, seen by the host at the next refresh
					if (wb_sel_in[0]) put_stage[7:0] <= wb_dat_in[7:0];
					if (wb_sel_in[1]) put_stage[15:8] <= wb_dat_in[15:8];
				end
				`HXI_OFF_SHMADDR: begin
					if (wb_sel_in[0]) shm_addr <= wb_dat_in[7:0];
				end
				default: begin
				end
				endcase
			end
		end
	end

	// transfer engine: unit-initiated and request-driven
	wire xf_start = wb_req & wb_we_in & ~wb_ack_out & wb_sel_in[0] &
		(wb_adr_in == `HXI_OFF_XFER) & (state == ST_IDLE);
	wire xf_last  = (xf_cnt == 8'h01);

	always @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state    <= ST_IDLE;
			xf_cnt   <= 8'h00;
			xf_idx   <= 8'h00;
			xf_base  <= 8'h00;
			xf_dir   <= 1'b0;
			xf_req   <= 1'b0;
			xf_phase <= 3'h0;
			wr_req   <= 1'b0;
			rd_req   <= 1'b0;
			host_busy_out      <= 1'b0;
			host_mem_req_out   <= 1'b0;
			host_mem_we_out    <= 1'b0;
			host_mem_idx_out   <= 8'h00;
			host_mem_wdata_out <= 16'h0000;
			host_status_out    <= 16'h0000;
		end else if (ce_in) begin
			host_status_out <= 16'h0000;
			host_status_out[`HXI_WRREQ_BIT] <= wr_req;
			host_status_out[`HXI_RDREQ_BIT] <= rd_req;
			host_mem_req_out   <= (state == ST_MOVE) & s_ref;
			host_mem_we_out    <= xf_dir;
			host_mem_idx_out   <= xf_idx;
			host_mem_wdata_out <= m_rc;
			case (state)
			ST_IDLE: begin
				if (xf_start) begin
					xf_cnt   <= wb_dat_in[7:0];
					xf_idx   <= 8'h00;
					xf_base  <= wb_dat_in[`HXI_XF_BASE_MSB:`HXI_XF_BASE_LSB];
					xf_dir   <= wb_dat_in[`HXI_XF_DIR];
					xf_req   <= wb_dat_in[`HXI_XF_REQ];
					xf_phase <= 3'h0;
					state    <= (wb_dat_in[7:0] == 8'h00) ? ST_DONE : ST_ARM;
				end
			end
			ST_ARM: begin
				if (ref_rise) begin
					if (xf_req) begin
						wr_req <= ~xf_dir;
						rd_req <= xf_dir;
						state  <= ST_REQ;
					end else begin
						host_busy_out <= 1'b1;
						state         <= ST_MOVE;
					end
				end
			end
			ST_MOVE: begin
				// pauses between refresh windows, resumes at the next
				if (!s_ref) begin
					xf_phase <= 3'h0;
				end else if (xf_capture) begin
					if (xf_step) begin
						xf_phase <= 3'h0;
						xf_idx   <= xf_idx + 8'h01;
						xf_cnt   <= xf_cnt - 8'h01;
						if (xf_last) begin
							host_busy_out <= 1'b0;
							state         <= ST_DONE;
						end
					end
				end else begin
					xf_phase <= xf_phase + 3'h1;
				end
			end
			ST_REQ: begin
				if (req_wr || req_rd) begin
					xf_idx <= xf_idx + 8'h01;
					xf_cnt <= xf_cnt - 8'h01;
					if (xf_last) begin
						wr_req <= 1'b0;
						rd_req <= 1'b0;
						state  <= ST_DONE;
					end
				end
			end
			ST_DONE: begin
				if (wb_ack_out) begin
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// bus slave; an xfer write is answered only when the transfer ends
	reg        next_ack;
	reg [31:0] rd_mux;

	always @* begin
		next_ack = 1'b0;
		if (wb_req && !wb_ack_out) begin
			if (wb_we_in && wb_adr_in == `HXI_OFF_XFER) begin
				next_ack = (state == ST_DONE);
			end else begin
				next_ack = 1'b1;
			end
		end
		rd_mux = 32'h00000000;
		case (wb_adr_in)
		`HXI_OFF_STATUS:   rd_mux[`HXI_NEV-1:0] = status;
		`HXI_OFF_MASK:     rd_mux[`HXI_NEV-1:0] = mask;
		`HXI_OFF_CTRL:     rd_mux[`HXI_CTRL_EN] = irq_en;
		`HXI_OFF_DISPATCH: rd_mux[9:0] = {pv, run, num};
		`HXI_OFF_PUT:      rd_mux[15:0] = put_stage;
		`HXI_OFF_GET0:     rd_mux[15:0] = get0;
		`HXI_OFF_GET1:     rd_mux[15:0] = get1;
		`HXI_OFF_XFER:     rd_mux[23:0] = {xf_base, 6'h00,
			(state != ST_IDLE), host_busy_out, xf_cnt};
		`HXI_OFF_SHMADDR:  rd_mux[7:0] = shm_addr;
		`HXI_OFF_SHMDATA:  rd_mux[15:0] = m_ra;
		default:           rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else if (ce_in) begin
			wb_ack_out <= next_ack;
			if (next_ack) begin
				wb_dat_out <= wb_we_in ? 32'h00000000 : rd_mux;
			end
		end
	end
endmodule // hxi_top
`default_nettype wire

// [rtl/hxi_consts.vh]
// constants for the host exchange and interrupt port
`ifndef HXI_CONSTS_VH
`define HXI_CONSTS_VH

// register byte offsets on the wishbone slave
`define HXI_OFF_STATUS   8'h00
`define HXI_OFF_MASK     8'h04
`define HXI_OFF_CTRL     8'h08
`define HXI_OFF_DISPATCH 8'h0C
`define HXI_OFF_PUT      8'h10
`define HXI_OFF_GET0     8'h14
`define HXI_OFF_GET1     8'h18
`define HXI_OFF_XFER     8'h1C
`define HXI_OFF_SHMADDR  8'h20
`define HXI_OFF_SHMDATA  8'h24

// sticky event bits
`define HXI_NEV          4
`define HXI_EV_DISPATCH  0
`define HXI_EV_XFER_DONE 1
`define HXI_EV_SHM_WRITE 2
`define HXI_EV_DROPPED   3

// reset values
`define HXI_MASK_RST     4'h0
`define HXI_CTRL_EN_RST  1'b1
`define HXI_PUT_RST      16'h0000

// fields
`define HXI_CTRL_EN      0
`define HXI_DONE_BIT     0
`define HXI_XF_DIR       8
`define HXI_XF_REQ       9
`define HXI_XF_BASE_LSB  16
`define HXI_XF_BASE_MSB  23
`define HXI_IRQ_BIT      4
`define HXI_WRREQ_BIT    15
`define HXI_RDREQ_BIT    14

// host special-unit control codes
`define HXI_CODE_IRQ     16'hCC00
`define HXI_CODE_REQ     16'hFD00
`define HXI_CODE_SHM     8'h00

// phase at which a host word is taken (covers the input sync delay)
`define HXI_XFER_GAP     3'h3
`define HXI_SHM_DEPTH    256

`endif

// [rtl/hxi_sync.v]
// two-flop synchroniser for a bundle of host pins
`timescale 1ns/1ps
`default_nettype none
module hxi_sync #(
	parameter W = 1
) (
	input  wire         clk_sys_in, // system clock
	input  wire         nrst_in,    // async reset, active low
	input  wire         ce_in,      // clock enable
	input  wire [W-1:0] d_in,       // asynchronous pins
	output wire [W-1:0] q_out       // synchronised copy
);
	reg [W-1:0] meta;
	reg [W-1:0] stable;

	always @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta   <= {W{1'b0}};
			stable <= {W{1'b0}};
		end else if (ce_in) begin
			meta   <= d_in;
			stable <= meta;
		end
	end

	assign q_out = stable;
endmodule // hxi_sync
`default_nettype wire

// [rtl/hxi_shmem.v]
// shared memory: one write port, three asynchronous read ports
`timescale 1ns/1ps
`default_nettype none
`include "hxi_consts.vh"
module hxi_shmem (
	input  wire        clk_sys_in, // system clock
	input  wire        ce_in,      // clock enable
	input  wire        we_in,      // write strobe
	input  wire [7:0]  widx_in,    // write index
	input  wire [15:0] wdata_in,   // write data
	input  wire [7:0]  ra_idx_in,  // read index a
	input  wire [7:0]  rb_idx_in,  // read index b
	input  wire [7:0]  rc_idx_in,  // read index c
	output wire [15:0] ra_out,     // read data a
	output wire [15:0] rb_out,     // read data b
	output wire [15:0] rc_out      // read data c
);
	// data storage only, so no reset: contents are undefined until written
	reg [15:0] mem [0:`HXI_SHM_DEPTH-1];

	always @(posedge clk_sys_in) begin
		if (ce_in && we_in) begin
			mem[widx_in] <= wdata_in;
		end
	end

	assign ra_out = mem[ra_idx_in];
	assign rb_out = mem[rb_idx_in];
	assign rc_out = mem[rc_idx_in];
endmodule // hxi_shmem
`default_nettype wire

// [verification/hxi_properties.sv]
// concurrent checks on the ports of the host exchange and interrupt port
`timescale 1ns/1ps
`default_nettype none
module hxi_properties (
	input wire logic        clk_sys_in,        // clock
	input wire logic        nrst_in,           // reset, active low
	input wire logic        wb_cyc_in,         // bus cycle
	input wire logic        wb_stb_in,         // bus strobe
	input wire logic        wb_we_in,          // bus write
	input wire logic [31:0] wb_dat_out,        // read data
	input wire logic        wb_ack_out,        // acknowledge
	input wire logic        host_refresh_in,   // refresh window
	input wire logic        host_mem_req_out,  // host access active
	input wire logic        host_mem_we_out,   // access writes host
	input wire logic [7:0]  host_mem_idx_out,  // word offset
	input wire logic [15:0] host_status_out,   // word n+5
	input wire logic [15:0] host_put_word_out, // word n+6
	input wire logic        host_busy_out      // busy flag
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without a request");
	a_dat_hold: assert property (!wb_ack_out |-> $stable(wb_dat_out))
		else $error("read data moved between acks");
	a_req_refresh: assert property (
		!host_refresh_in [*6] |-> !host_mem_req_out)
		else $error("host access outside refresh");
	a_req_busy: assert property ($rose(host_mem_req_out) |-> host_busy_out)
		else $error("host access without busy");
	a_busy_rise: assert property (
		$rose(host_busy_out) |-> $past(host_refresh_in, 2))
		else $error("busy rose outside refresh");
	a_flag_rise: assert property (
		$rose(host_status_out[15]) |-> $past(host_refresh_in, 2))
		else $error("write request flag rose outside refresh");
	a_idx_limit: assert property (host_mem_req_out |-> host_mem_idx_out != 8'hFF)
		else $error("transfer beyond 255 words");
	a_dir_fixed: assert property (
		host_mem_req_out && $past(host_mem_req_out) |-> $stable(host_mem_we_out))
		else $error("direction changed in a transfer");
	a_put_cause: assert property ($changed(host_put_word_out) |->
		$past(wb_ack_out && wb_we_in) || $past(host_refresh_in, 3))
		else $error("put word changed with no cause");
endmodule // hxi_properties

bind hxi_top hxi_properties u_hxi_properties (.clk_sys_in(clk_sys_in),
	.nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.host_refresh_in(host_refresh_in), .host_mem_req_out(host_mem_req_out),
	.host_mem_we_out(host_mem_we_out), .host_mem_idx_out(host_mem_idx_out),
	.host_status_out(host_status_out), .host_busy_out(host_busy_out),
	.host_put_word_out(host_put_word_out));
`default_nettype wire

// [verification/hxi_host.sv]
// behavioural host cpu on the far side of the exchange port
`timescale 1ns/1ps
`default_nettype none
`include "hxi_consts.vh"
module hxi_host (
	input  wire logic        clk_sys_in,   // clock
	input  wire logic        mem_req_in,   // unit host access
	input  wire logic        mem_we_in,    // access writes host
	input  wire logic [7:0]  mem_idx_in,   // word offset
	input  wire logic [15:0] mem_wdata_in, // unit write data
	input  wire logic [15:0] status_in,    // word n+5
	output logic             refresh_out,  // i/o refresh window
	output logic [15:0]      word0_out,    // word n
	output logic [15:0]      word1_out,    // word n+1
	output logic [15:0]      word2_out,    // word n+2
	output logic             sp_wr_out,    // special write strobe
	output logic             sp_rd_out,    // special read strobe
	output logic [15:0]      sp_code_out,  // control code
	output logic [15:0]      sp_data_out,  // special write data
	output logic [15:0]      mem_rdata_out // host memory data
);
	logic        ref_on = 1'b0;
	int          gap = 4;
	int          k = 0;
	int          hold = 0;
	logic [15:0] last = 16'h0000;
	logic [15:0] hmem [256];
	initial begin
		{refresh_out, sp_wr_out, sp_rd_out} = 3'h0;
		{word0_out, word1_out, word2_out} = 48'h0;
		{sp_code_out, sp_data_out} = 32'h0;
		for (int i = 0; i < 256; i++) hmem[i] = 16'h1000 + i[15:0];
	end
	// refresh windows are the only time the unit may reach host memory
	always begin
		repeat (20) @(posedge clk_sys_in);
		if (ref_on) begin
			refresh_out <= 1'b1;
			repeat (30) @(posedge clk_sys_in);
			refresh_out <= 1'b0;
		end
	end
	// data follows req at once; released lines toggle so stale words show
	assign mem_rdata_out = (mem_req_in || hold > 0) ? hmem[mem_idx_in] :
		~last;
	always @(posedge clk_sys_in) begin
		hold <= (mem_req_in && !mem_we_in) ? 6 : (hold > 0 ? hold - 1 : 0);
		last <= mem_rdata_out;
		if (mem_req_in && mem_we_in) hmem[mem_idx_in] <= mem_wdata_in;
	end
	// control code chooses shared memory, interrupt or request service
	task automatic sp(input logic wr, input logic [15:0] c, input logic [15:0] d);
		sp_code_out <= c;
		sp_data_out <= d;
		sp_wr_out <= wr;
		sp_rd_out <= !wr;
		repeat (4) @(posedge clk_sys_in);
		sp_wr_out <= 1'b0;
		sp_rd_out <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
	endtask
	// gap sets how slowly the host notices a raised request flag
	always @(posedge clk_sys_in)
		if (status_in[15] || status_in[14]) begin
			repeat (gap) @(posedge clk_sys_in);
			if (status_in[15] || status_in[14])
				sp(status_in[15], `HXI_CODE_REQ, 16'hC000 + k[15:0]);
			k++;
		end
endmodule // hxi_host
`default_nettype wire

// [verification/test_hxi_top.sv]
// self-checking bench for the host exchange and interrupt port
`timescale 1ns/1ps
`default_nettype none
`include "hxi_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_hxi_top;
	logic        clk_sys_in = 1'b0;
	logic        nrst_in    = 1'b0;
	logic        wb_cyc_in  = 1'b0;
	logic        wb_stb_in  = 1'b0;
	logic        wb_we_in   = 1'b0;
	logic [7:0]  wb_adr_in  = 8'h00;
	logic [31:0] wb_dat_in  = 32'h0;
	logic [31:0] rd;
	int          err_count  = 0;
	int          n_compared = 0;
	wire  [31:0] wb_dat_out;
	wire         wb_ack_out, irq_out, host_refresh_in, host_sp_wr_in;
	wire         host_sp_rd_in, host_mem_req_out, host_mem_we_out, host_busy_out;
	wire  [15:0] host_word0_in, host_word1_in, host_word2_in, host_sp_code_in;
	wire  [15:0] host_sp_data_in, host_sp_rdata_out, host_mem_rdata_in;
	wire  [15:0] host_mem_wdata_out, host_status_out, host_put_word_out;
	wire  [7:0]  host_mem_idx_out;
	always #5 clk_sys_in = ~clk_sys_in;
	hxi_top u_hxi_top (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(1'b1),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(4'hF), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_out(irq_out),
		.host_refresh_in(host_refresh_in), .host_word0_in(host_word0_in),
		.host_word1_in(host_word1_in), .host_word2_in(host_word2_in),
		.host_sp_wr_in(host_sp_wr_in), .host_sp_rd_in(host_sp_rd_in),
		.host_sp_code_in(host_sp_code_in), .host_sp_data_in(host_sp_data_in),
		.host_sp_rdata_out(host_sp_rdata_out),
		.host_mem_rdata_in(host_mem_rdata_in),
		.host_mem_req_out(host_mem_req_out), .host_mem_we_out(host_mem_we_out),
		.host_mem_idx_out(host_mem_idx_out),
		.host_mem_wdata_out(host_mem_wdata_out),
		.host_status_out(host_status_out), .host_put_word_out(host_put_word_out),
		.host_busy_out(host_busy_out));
	hxi_host u_hxi_host (.clk_sys_in(clk_sys_in), .mem_req_in(host_mem_req_out),
		.mem_we_in(host_mem_we_out), .mem_idx_in(host_mem_idx_out),
		.mem_wdata_in(host_mem_wdata_out), .status_in(host_status_out),
		.refresh_out(host_refresh_in), .word0_out(host_word0_in),
		.word1_out(host_word1_in), .word2_out(host_word2_in),
		.sp_wr_out(host_sp_wr_in), .sp_rd_out(host_sp_rd_in),
		.sp_code_out(host_sp_code_in), .sp_data_out(host_sp_data_in),
		.mem_rdata_out(host_mem_rdata_in));
	task automatic conclude();
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int n;
		@(posedge clk_sys_in);
		{wb_cyc_in, wb_stb_in, wb_we_in} <= {2'h3, we};
		wb_adr_in <= a;
		wb_dat_in <= d;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			err_count++;
			conclude();
		end
		r = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, rd);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, rd);
		`CHK(rd, e)
	endtask
	function automatic logic sig(input int s);
		return s == 0 ? irq_out : (s == 1 ? host_busy_out : host_refresh_in);
	endfunction
	// bounded wait on irq (0), busy (1) or refresh (2)
	task automatic waitv(input int s, input logic v);
		int n;
		n = 0;
		while (sig(s) !== v && n < 3000) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			conclude();
		end
	endtask
	task automatic ref_pass();
		waitv(2, 1'b1);
		waitv(2, 1'b0);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		rdchk(`HXI_OFF_MASK, 32'h0);
		rdchk(`HXI_OFF_CTRL, 32'h1);
		rdchk(`HXI_OFF_STATUS, 32'h0);
		wr(8'h80, 32'hFFFF);
		rdchk(8'h80, 32'h0);
		wr(`HXI_OFF_PUT, 32'h5A3C);
		`CHK(host_put_word_out, 16'h0000);
		u_hxi_host.word0_out <= 16'h1224;
		u_hxi_host.word1_out <= 16'hABCD;
		u_hxi_host.word2_out <= 16'h002A;
		u_hxi_host.ref_on <= 1'b1;
		ref_pass();
		`CHK(host_put_word_out, 16'h5A3C);
		rdchk(`HXI_OFF_GET0, 32'h1224);
		rdchk(`HXI_OFF_GET1, 32'hABCD);
		u_hxi_host.ref_on <= 1'b0;
		wr(`HXI_OFF_MASK, 32'h1);
		u_hxi_host.word0_out <= 16'h1234;
		repeat (60) @(posedge clk_sys_in);
		`CHK(irq_out, 1'b0);
		u_hxi_host.ref_on <= 1'b1;
		waitv(0, 1'b1);
		rdchk(`HXI_OFF_DISPATCH, 32'h12A);
		wr(`HXI_OFF_STATUS, 32'h1);
		wr(`HXI_OFF_DISPATCH, 32'h1);
		@(negedge clk_sys_in);
		`CHK(irq_out, 1'b0);
		u_hxi_host.word0_out <= 16'h1224;
		ref_pass();
		u_hxi_host.ref_on <= 1'b0;
		u_hxi_host.sp(1'b1, `HXI_CODE_IRQ, 16'h0055);
		repeat (60) @(posedge clk_sys_in);
		`CHK(irq_out, 1'b0);
		u_hxi_host.ref_on <= 1'b1;
		waitv(0, 1'b1);
		rdchk(`HXI_OFF_DISPATCH, 32'h155);
		wr(`HXI_OFF_MASK, 32'h0);
		@(negedge clk_sys_in);
		`CHK(irq_out, 1'b0);
		wr(`HXI_OFF_DISPATCH, 32'h1);
		u_hxi_host.sp(1'b1, 16'h0007, 16'hBEEF);
		u_hxi_host.sp(1'b0, 16'h0007, 16'h0000);
		`CHK(host_sp_rdata_out, 16'hBEEF);
		wr(`HXI_OFF_SHMADDR, 32'h7);
		rdchk(`HXI_OFF_SHMDATA, 32'hBEEF);
		wr(`HXI_OFF_STATUS, 32'hF);
		// a word interrupt raised mid-transfer must be dropped
		fork
			wr(`HXI_OFF_XFER, 32'h0000_00FF);
			begin
				waitv(1, 1'b1);
				u_hxi_host.word0_out <= 16'h1234;
			end
		join
		rdchk(`HXI_OFF_STATUS, 32'hA);
		wr(`HXI_OFF_SHMADDR, 32'hFE);
		rdchk(`HXI_OFF_SHMDATA, 32'h10FE);
		wr(`HXI_OFF_SHMADDR, 32'h0);
		rdchk(`HXI_OFF_SHMDATA, 32'h1000);
		wr(`HXI_OFF_XFER, 32'h0040_0102);
		`CHK(u_hxi_host.hmem[1], 16'h1041);
		`CHK(u_hxi_host.hmem[0], 16'h1040);
		u_hxi_host.gap <= 12;
		wr(`HXI_OFF_XFER, 32'h0080_0202);
		`CHK(host_status_out[15], 1'b0);
		wr(`HXI_OFF_SHMADDR, 32'h81);
		rdchk(`HXI_OFF_SHMDATA, 32'hC001);
		wr(`HXI_OFF_XFER, 32'h0080_0301);
		`CHK(host_sp_rdata_out, 16'hC000);
		conclude();
	end
endmodule // test_hxi_top
`default_nettype wire
